// file: bench/lpps_checker.sv
// Assertion checker bound to the load port and panel sequencer
`timescale 1ns/1ps
module lpps_checker #(parameter int unsigned MENU_OPTIONS = 4) (
    input wire logic       clk, arst_n, front_door_interlock,    // Clock, reset, interlock
    input wire logic       open_led, close_led, park_req,        // Port indicators, park
    input wire logic       port_lock_solenoid, stop_led,         // Lock, stop indicator
    input wire logic       robot_power_en, motor_power_en,       // Power enables
    input wire logic       host_comm_en, service_port_en,        // Online, offline
    input wire logic       menu_active, menu_exec,               // Menu state, execute
    input wire logic       panel_sclk, panel_latch,              // Panel link
    input wire logic [3:0] menu_index                            // Shown option
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_HOST: assert property (host_comm_en |-> !service_port_en)
        else $error("host link and service port both on");
    AST_STOP: assert property (stop_led |-> !robot_power_en && !motor_power_en)
        else $error("stop lit with power on");
    AST_MOTOR: assert property (motor_power_en |-> robot_power_en)
        else $error("motor power without robot power");
    AST_DOOR: assert property (!front_door_interlock [*8] |=> !motor_power_en)
        else $error("motor power with front door open");
    AST_PARK: assert property ((open_led || close_led || port_lock_solenoid) |-> park_req)
        else $error("port activity without park request");
    AST_LEDS: assert property (open_led |-> !close_led)
        else $error("open and close indicators both lit");
    AST_EXEC: assert property (menu_exec |-> menu_active ##1 !menu_exec)
        else $error("execute pulse outside menu or too long");
    AST_INDEX: assert property (menu_active |-> menu_index < MENU_OPTIONS)
        else $error("menu index out of range");
    AST_MENU: assert property ($rose(menu_active) |-> service_port_en)
        else $error("menu entered while online");
    AST_SCLK: assert property (panel_sclk |=> !panel_sclk)
        else $error("panel clock high too long");
    cover property ($rose(port_lock_solenoid));
    cover property (menu_exec);
    cover property ($rose(service_port_en));
endmodule
bind lpps_sequencer lpps_checker #(.MENU_OPTIONS(MENU_OPTIONS)) u_chk (.*);

// file: bench/lpps_door_model.sv
// Load port door mechanics with its two limit switches
`timescale 1ns/1ps
module lpps_door_model (
    input wire logic clk,                       // System clock
    input wire logic arst_n,                    // Async reset, low
    input wire logic port_lock_solenoid,        // High unlocks
    input wire logic push,                      // Operator pushes door shut
    output logic     door_open_limit_switch,    // At open end
    output logic     door_closed_limit_switch   // At closed end
);
    logic [3:0] pos_reg;
    logic       up_reg, mv_reg;
    // Door slides only once unlocked, then runs to the far end
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) {pos_reg, up_reg, mv_reg} <= 6'h02;
        else if (mv_reg) begin
            pos_reg <= up_reg ? pos_reg + 4'h1 : pos_reg - 4'h1;
            mv_reg  <= up_reg ? pos_reg != 4'hE : pos_reg != 4'h1;
        end
        else if (port_lock_solenoid && pos_reg == 4'h0) {up_reg, mv_reg} <= 2'h3;
        else if (port_lock_solenoid && push && pos_reg == 4'hF) {up_reg, mv_reg} <= 2'h1;
    assign door_open_limit_switch   = pos_reg == 4'hF;
    assign door_closed_limit_switch = pos_reg == 4'h0;
endmodule

// file: bench/test_lpps_sequencer.sv
// Self-checking bench for the load port and panel sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_lpps_sequencer;
    import lpps_pkg::*;
    logic clk = 0, arst_n, front_door_interlock, park_done, online_op_busy;
    logic error_cond, push, park_req, port_lock_solenoid, open_led, close_led;
    logic standby_led, stop_led, fault_led, robot_power_en, motor_power_en, host_comm_en;
    logic service_port_en, menu_active, menu_exec, panel_sclk, panel_sdata, panel_latch;
    logic door_open_limit_switch, door_closed_limit_switch;
    logic [3:0] menu_index, v, v_last;
    logic [6:0] b;
    logic [8:0] q[$];
    int n_fail = 0, check_count = 0, n;
    wire open_btn, close_btn, standby_btn, stop_btn, select_btn, up_btn, down_btn;
    assign {down_btn, up_btn, select_btn, stop_btn, standby_btn, close_btn, open_btn} = b;
    assign v = {port_lock_solenoid, stop_led, robot_power_en, service_port_en};
    always #5 clk = ~clk;
    lpps_sequencer #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(8)) DUT (.clk, .arst_n, .open_btn, .close_btn,
        .standby_btn, .stop_btn, .select_btn, .up_btn, .down_btn, .door_open_limit_switch,
        .door_closed_limit_switch, .front_door_interlock, .park_done, .online_op_busy, .error_cond, .park_req,
        .port_lock_solenoid, .open_led, .close_led, .standby_led, .stop_led, .fault_led, .robot_power_en,
        .motor_power_en, .host_comm_en, .service_port_en, .menu_active, .menu_index, .menu_exec, .panel_sclk,
        .panel_sdata, .panel_latch);
    lpps_door_model PM (.clk, .arst_n, .port_lock_solenoid, .push, .door_open_limit_switch,
        .door_closed_limit_switch);
    // Robotics park after a random delay
    always @(posedge clk) park_done <= park_req && ($urandom % 5 == 0);
    // Each status change or execute pulse is compared with the oldest note
    always @(posedge clk) begin
        if (arst_n && (v !== v_last || menu_exec === 1'b1)) begin
            if (q.size() == 0) q.push_back(9'h1FF);
            `CHK(menu_exec ? {1'b1, menu_index, v} : {5'h00, v}, q.pop_front())
        end
        v_last <= v;
    end
    task automatic cyc(input int k); repeat (k) @(posedge clk); endtask
    task automatic press(input int i, input int len = 8);
        b[i] <= 1'b1;
        cyc(len);
        b[i] <= 1'b0;
        cyc(8);
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic fin(input string s);
        for (int k = 0; k < 500 && q.size() > 0; k++) cyc(1);
        if (q.size() > 0) begin n_fail++; report_and_stop(); end
        cyc(30);
        $display("test %s done", s);
    endtask
    // Main sequence
    initial begin
        void'($urandom(37));
        {arst_n, front_door_interlock, online_op_busy, error_cond, push, b} = 12'h400;
        q.push_back(9'h002);
        cyc(5);
        arst_n <= 1'b1;
        fin("reset");
        press(0, 2); press(1); press(4); fin("glitch and refused");
        q.push_back(9'h00A); q.push_back(9'h002); press(0); fin("open");
        q.push_back(9'h00A); q.push_back(9'h002); press(1); push <= 1'b1; fin("close");
        push <= 1'b0;
        q.push_back(9'h004); q.push_back(9'h002); press(3); press(3); fin("stop");
        front_door_interlock <= 1'b0; cyc(20);
        `CHK(motor_power_en, 1'b0)
        front_door_interlock <= 1'b1; fin("door");
        online_op_busy <= 1'b1; error_cond <= 1'b1; press(2); cyc(20); q.push_back(9'h003);
        `CHK(fault_led, 1'b1)
        online_op_busy <= 1'b0; error_cond <= 1'b0; fin("offline");
        `CHK(standby_led, 1'b1)
        n = $urandom % 6;
        press(4); press(6); repeat (n) press(5);
        q.push_back({1'b1, 4'((MENU_COUNT - 1 + n) % MENU_COUNT), 4'h3}); press(4); fin("menu");
        q.push_back(9'h002); press(2); fin("online");
        report_and_stop();
    end
endmodule

// file: hw/lpps_deb_if.sv
// Carrier between the sequencer and its contact debouncer
`timescale 1ns/1ps
interface lpps_deb_if #(
    parameter int unsigned N = 10
);
    logic [N-1:0] raw;                                          // Contact levels in
    logic [N-1:0] level;                                        // Settled levels
    logic [N-1:0] press;                                        // One-cycle rise pulses

    modport user (output raw, input level, input press);
    modport deb  (input raw, output level, output press);
endinterface

// file: hw/lpps_debounce.sv
// Per-contact debouncer producing settled levels and press pulses
`timescale 1ns/1ps
module lpps_debounce #(
    parameter int unsigned N      = 10,
    parameter int unsigned SETTLE = 500000
) (
    input  wire logic  clk,                                     // System clock
    input  wire logic  arst_n,                                  // Async reset, low
    lpps_deb_if.deb    dbus                                     // Contact carrier
);
    localparam int unsigned CW = $clog2(SETTLE + 1);

    // ------------------------------------------------------------
    // One settle counter per contact
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ch
            logic [CW-1:0] cnt_reg;
            logic          lvl_reg;
            logic          prs_reg;

            // A level change must hold for the whole settle time
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    cnt_reg <= '0;
                    lvl_reg <= 1'b0;
                    prs_reg <= 1'b0;
                end
                else
                begin
                    prs_reg <= 1'b0;
                    if (dbus.raw[g] == lvl_reg)
                        cnt_reg <= '0;
                    else if (cnt_reg == CW'(SETTLE - 1))
                    begin
                        cnt_reg <= '0;
                        lvl_reg <= dbus.raw[g];
                        prs_reg <= dbus.raw[g];                 // Rise only, once per press
                    end
                    else
                        cnt_reg <= cnt_reg + CW'(1);
                end
            end

            assign dbus.level[g] = lvl_reg;
            assign dbus.press[g] = prs_reg;
        end
    endgenerate

endmodule

// file: hw/lpps_pkg.sv
// Shared constants and types for the load port and panel sequencer
package lpps_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ         = 100000;           // 100 MHz clock
    localparam int unsigned DEBOUNCE_MS     = 5;                // Contact settle time
    localparam int unsigned BLINK_HALF_MS   = 250;              // Indicator half period
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CLK_KHZ;
    localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * CLK_KHZ;

    // ------------------------------------------------------------
    // Inputs, panel and menu layout
    // ------------------------------------------------------------
    localparam int unsigned NUM_INPUTS      = 10;               // Debounced contacts
    localparam int unsigned IN_OPEN         = 0;
    localparam int unsigned IN_CLOSE        = 1;
    localparam int unsigned IN_STANDBY      = 2;
    localparam int unsigned IN_STOP         = 3;
    localparam int unsigned IN_SELECT       = 4;
    localparam int unsigned IN_UP           = 5;
    localparam int unsigned IN_DOWN         = 6;
    localparam int unsigned IN_DOOR_OPEN    = 7;
    localparam int unsigned IN_DOOR_CLOSED  = 8;
    localparam int unsigned IN_INTERLOCK    = 9;
    localparam int unsigned PANEL_COLS      = 16;               // Characters per line
    localparam int unsigned PANEL_LINES     = 2;
    localparam int unsigned FRAME_BITS      = 16;               // Serial frame length
    localparam int unsigned MENU_COUNT      = 4;                // Menu options
    localparam logic [7:0]  CHAR_ZERO       = 8'h30;

    // ------------------------------------------------------------
    // Panel messages, sixteen characters each
    // ------------------------------------------------------------
    localparam logic [127:0] MSG_ONLINE     = "LIBRARY ONLINE  ";
    localparam logic [127:0] MSG_OFFLINE    = "LIBRARY OFFLINE ";
    localparam logic [127:0] MSG_GOING_OFF  = "GOING OFFLINE   ";
    localparam logic [127:0] MSG_PARKING    = "PARKING ROBOTICS";
    localparam logic [127:0] MSG_PORT_OPEN  = "LOAD PORT OPEN  ";
    localparam logic [127:0] MSG_CLOSE_PORT = "CLOSE LOAD PORT ";
    localparam logic [127:0] MSG_STOPPED    = "ROBOTICS STOPPED";
    localparam logic [127:0] MSG_FAULT      = "LIBRARY FAULT   ";
    localparam logic [127:0] MSG_MENU       = "MENU MODE       ";
    localparam logic [127:0] MSG_OPTION     = "OPTION          ";
    localparam logic [127:0] MSG_BLANK      = "                ";

    // ------------------------------------------------------------
    // Load port sequence states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        PORT_CLOSED       = 6'h01,
        PORT_OPEN_PARK    = 6'h02,
        PORT_OPEN_UNLOCK  = 6'h04,
        PORT_OPENED       = 6'h08,
        PORT_CLOSE_PARK   = 6'h10,
        PORT_CLOSE_UNLOCK = 6'h20
    } lpps_port_t;

endpackage

// file: hw/lpps_sequencer.sv
// Load port, indicator, standby, stop, menu and panel sequencer
`timescale 1ns/1ps

// What this block does
// - Open press parks robotics, green indicator blinks until parked.
// - After parking, unlock so the door opens, green indicator steady.
// - Once door is open, lock it there and turn green indicator off.
// - With door open, close press parks robotics, red indicator blinks.
// - Then unlock with red steady; door shut by operator locks closed.
// - Door-open limit switch actuated means the door is open.
// - Door-closed limit switch actuated means the door is closed.
// - Solenoid unlocks; drop it once the door leaves its limit switch.
// - Front door opened removes motor power.
// - Standby press online goes offline: indicator on, host off, menus, service.
// - Standby press offline returns online with indicator off.
// - Standby indicator blinks while offline waits for online work to end.
// - Stop toggles robotic power and the red stop indicator.
// - Select enters menu mode only in standby.
// - Up and down step menu options; select executes the shown option.
// - Fault indicator lit during error, with a fault message shown.
// - Two-line sixteen-character panel shows status, or menu options.
// - Panel data travels to the panel over a synchronous serial link.
module lpps_sequencer
    import lpps_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned BLINK_CYCLES    = BLINK_HALF_CYC,
    parameter int unsigned MENU_OPTIONS    = MENU_COUNT
) (
    input  wire logic       clk,                                // System clock
    input  wire logic       arst_n,                             // Async reset, low
    input  wire logic       open_btn,                           // Load port open button
    input  wire logic       close_btn,                          // Load port close button
    input  wire logic       standby_btn,                        // Online/offline button
    input  wire logic       stop_btn,                           // Robotics stop button
    input  wire logic       select_btn,                         // Menu select button
    input  wire logic       up_btn,                             // Menu scroll up
    input  wire logic       down_btn,                           // Menu scroll down
    input  wire logic       door_open_limit_switch,             // High when actuated
    input  wire logic       door_closed_limit_switch,           // High when actuated
    input  wire logic       front_door_interlock,               // High when contact closed
    input  wire logic       park_done,                          // Robotics report parked
    input  wire logic       online_op_busy,                     // Host operation running
    input  wire logic       error_cond,                         // Library error present
    output logic            park_req,                           // Ask robotics to park
    output logic            port_lock_solenoid,                 // High unlocks the port
    output logic            open_led,                           // Green open indicator
    output logic            close_led,                          // Red close indicator
    output logic            standby_led,                        // Standby indicator
    output logic            stop_led,                           // Red stop indicator
    output logic            fault_led,                          // Red fault indicator
    output logic            robot_power_en,                     // Robotic power allowed
    output logic            motor_power_en,                     // Motor power switched on
    output logic            host_comm_en,                       // Host link enabled
    output logic            service_port_en,                    // Service port active
    output logic            menu_active,                        // Menu mode on
    output logic [3:0]      menu_index,                         // Option on line two
    output logic            menu_exec,                          // Execute pulse
    output logic            panel_sclk,                         // Panel serial clock
    output logic            panel_sdata,                        // Panel serial data
    output logic            panel_latch                         // Frame latch pulse
);

    // ------------------------------------------------------------
    // Debounced contacts
    // ------------------------------------------------------------
    localparam int unsigned BW = $clog2(BLINK_CYCLES + 1);

    lpps_deb_if #(.N(NUM_INPUTS)) dbus ();

    assign dbus.raw = {front_door_interlock, door_closed_limit_switch,
                       door_open_limit_switch, down_btn, up_btn, select_btn,
                       stop_btn, standby_btn, close_btn, open_btn};

    lpps_debounce #(
        .N      (NUM_INPUTS),
        .SETTLE (DEBOUNCE_CYCLES)
    ) u_deb (
        .clk    (clk),
        .arst_n (arst_n),
        .dbus   (dbus)
    );

    logic press_open;
    logic press_close;
    logic press_standby;
    logic press_stop;
    logic press_select;
    logic press_up;
    logic press_down;
    logic at_open;
    logic at_closed;
    logic door_shut;

    // Only settled edges and levels reach the sequencing logic
    assign press_open    = dbus.press[IN_OPEN];
    assign press_close   = dbus.press[IN_CLOSE];
    assign press_standby = dbus.press[IN_STANDBY];
    assign press_stop    = dbus.press[IN_STOP];
    assign press_select  = dbus.press[IN_SELECT];
    assign press_up      = dbus.press[IN_UP];
    assign press_down    = dbus.press[IN_DOWN];
    assign at_open       = dbus.level[IN_DOOR_OPEN];
    assign at_closed     = dbus.level[IN_DOOR_CLOSED];
    assign door_shut     = dbus.level[IN_INTERLOCK];

    // ------------------------------------------------------------
    // Blink timebase
    // ------------------------------------------------------------
    logic [BW-1:0] blink_cnt_reg;
    logic          blink_reg;

    // Shared square wave for every blinking indicator
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            blink_cnt_reg <= '0;
            blink_reg     <= 1'b0;
        end
        else if (blink_cnt_reg == BW'(BLINK_CYCLES - 1))
        begin
            blink_cnt_reg <= '0;
            blink_reg     <= ~blink_reg;
        end
        else
            blink_cnt_reg <= blink_cnt_reg + BW'(1);
    end

    // ------------------------------------------------------------
    // Load port sequence
    // ------------------------------------------------------------
    lpps_port_t port_reg;
    logic       left_reg;                                       // Door has left its start switch

    // Walks park, unlock, travel and relock for both directions
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_reg <= PORT_CLOSED;
            left_reg <= 1'b0;
        end
        else
        begin
            case (port_reg)
                PORT_CLOSED:
                begin
                    left_reg <= 1'b0;
                    if (press_open)
                        port_reg <= PORT_OPEN_PARK;
                end
                PORT_OPEN_PARK:
                    if (park_done)
                        port_reg <= PORT_OPEN_UNLOCK;
                PORT_OPEN_UNLOCK:
                begin
                    if (!at_closed)
                        left_reg <= 1'b1;
                    if (at_open && left_reg)
                    begin
                        port_reg <= PORT_OPENED;
                        left_reg <= 1'b0;
                    end
                end
                PORT_OPENED:
                    if (press_close)
                        port_reg <= PORT_CLOSE_PARK;
                PORT_CLOSE_PARK:
                    if (park_done)
                        port_reg <= PORT_CLOSE_UNLOCK;
                PORT_CLOSE_UNLOCK:
                begin
                    if (!at_open)
                        left_reg <= 1'b1;
                    if (at_closed && left_reg)
                    begin
                        port_reg <= PORT_CLOSED;
                        left_reg <= 1'b0;
                    end
                end
                default:
                    port_reg <= PORT_CLOSED;
            endcase
        end
    end

    // Solenoid and port indicators follow the sequence state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            park_req           <= 1'b0;
            port_lock_solenoid <= 1'b0;
            open_led           <= 1'b0;
            close_led          <= 1'b0;
        end
        else
        begin
            park_req  <= (port_reg != PORT_CLOSED);
            open_led  <= (port_reg == PORT_OPEN_PARK) ? blink_reg :
                         (port_reg == PORT_OPEN_UNLOCK);
            close_led <= (port_reg == PORT_CLOSE_PARK) ? blink_reg :
                         (port_reg == PORT_CLOSE_UNLOCK);
            port_lock_solenoid <= ((port_reg == PORT_OPEN_UNLOCK) && !left_reg && at_closed) ||
                                  ((port_reg == PORT_CLOSE_UNLOCK) && !left_reg && at_open);
        end
    end

    // ------------------------------------------------------------
    // Standby, stop and power
    // ------------------------------------------------------------
    logic online_reg;
    logic going_off_reg;
    logic stopped_reg;

    // Offline request waits for the running host operation
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            online_reg    <= 1'b1;
            going_off_reg <= 1'b0;
        end
        else if (!online_reg)
        begin
            going_off_reg <= 1'b0;
            if (press_standby)
                online_reg <= 1'b1;
        end
        else if (going_off_reg)
        begin
            if (!online_op_busy)
            begin
                online_reg    <= 1'b0;
                going_off_reg <= 1'b0;
            end
        end
        else if (press_standby)
            going_off_reg <= 1'b1;
    end

    // Stop toggles robotic power
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            stopped_reg <= 1'b0;
        else if (press_stop)
            stopped_reg <= ~stopped_reg;
    end

    // Power, host and indicator outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            standby_led     <= 1'b0;
            stop_led        <= 1'b0;
            fault_led       <= 1'b0;
            robot_power_en  <= 1'b0;
            motor_power_en  <= 1'b0;
            host_comm_en    <= 1'b0;
            service_port_en <= 1'b0;
        end
        else
        begin
            standby_led     <= going_off_reg ? blink_reg : !online_reg;
            host_comm_en    <= online_reg;
            service_port_en <= !online_reg;
            stop_led        <= stopped_reg;
            robot_power_en  <= !stopped_reg;
            motor_power_en  <= !stopped_reg && door_shut;
            fault_led       <= error_cond;
        end
    end

    // ------------------------------------------------------------
    // Menu mode
    // ------------------------------------------------------------
    // Entry only from standby; leaving standby drops the menu
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            menu_active <= 1'b0;
            menu_index  <= 4'h0;
            menu_exec   <= 1'b0;
        end
        else
        begin
            menu_exec <= 1'b0;
            if (online_reg)
            begin
                menu_active <= 1'b0;
                menu_index  <= 4'h0;
            end
            else if (!menu_active)
            begin
                if (press_select)
                    menu_active <= 1'b1;
            end
            else if (press_select)
                menu_exec <= 1'b1;
            else if (press_up)
                menu_index <= (menu_index == 4'(MENU_OPTIONS - 1)) ? 4'h0 : menu_index + 4'h1;
            else if (press_down)
                menu_index <= (menu_index == 4'h0) ? 4'(MENU_OPTIONS - 1) : menu_index - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Panel text and serial link
    // ------------------------------------------------------------
    logic [127:0] line1_msg;
    logic [127:0] line2_msg;
    logic [4:0]   pos_reg;                                      // Line bit 4, column bits 3:0
    logic [7:0]   cur_char;
    logic [15:0]  sh_reg;
    logic [4:0]   bit_reg;
    logic         ph_reg;

    // Message choice: fault first, then menu, port, stop, standby
    always_comb
    begin
        line2_msg = MSG_BLANK;
        if (error_cond)
            line1_msg = MSG_FAULT;
        else if (menu_active)
        begin
            line1_msg = MSG_MENU;
            line2_msg = MSG_OPTION;
            line2_msg[63:56] = CHAR_ZERO + {4'h0, menu_index};
        end
        else if (port_reg == PORT_OPEN_PARK || port_reg == PORT_CLOSE_PARK)
            line1_msg = MSG_PARKING;
        else if (port_reg == PORT_OPENED)
            line1_msg = MSG_PORT_OPEN;
        else if (port_reg == PORT_CLOSE_UNLOCK)
            line1_msg = MSG_CLOSE_PORT;
        else if (stopped_reg)
            line1_msg = MSG_STOPPED;
        else if (going_off_reg)
            line1_msg = MSG_GOING_OFF;
        else if (!online_reg)
            line1_msg = MSG_OFFLINE;
        else
            line1_msg = MSG_ONLINE;
        cur_char = pos_reg[4] ? line2_msg[8 * (15 - pos_reg[3:0]) +: 8]
                              : line1_msg[8 * (15 - pos_reg[3:0]) +: 8];
    end

    // Frames of position and character, MSB first, data set on low clock
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pos_reg     <= 5'h00;
            sh_reg      <= 16'h0000;
            bit_reg     <= 5'h10;
            ph_reg      <= 1'b0;
            panel_sclk  <= 1'b0;
            panel_sdata <= 1'b0;
            panel_latch <= 1'b0;
        end
        else
        begin
            panel_latch <= 1'b0;
            ph_reg      <= ~ph_reg;
            if (!ph_reg)
            begin
                panel_sclk <= 1'b0;
                if (bit_reg == 5'(FRAME_BITS))
                begin
                    // Clock rests low only before the first frame, so that empty load is not latched
                    panel_latch <= panel_sclk;
                    sh_reg      <= {3'h0, pos_reg, cur_char};
                    pos_reg     <= pos_reg + 5'h01;
                    bit_reg     <= 5'h00;
                    ph_reg      <= 1'b0;
                end
                else
                    panel_sdata <= sh_reg[15];
            end
            else
            begin
                panel_sclk <= 1'b1;
                sh_reg     <= {sh_reg[14:0], 1'b0};
                bit_reg    <= bit_reg + 5'h01;
            end
        end
    end

endmodule
